// ---- hdl/lpm_sequencer.sv ----
// Wait/stop sequencer with reset cause and break flag registers
//
// Strobed register access was left to the implementer.
`timescale 1ns/10ps
`include "lpm_map.svh"
module lpm_sequencer
  import lpm_pkg::*;
#(
  parameter int LONG_RECOVERY  = `LPM_RECOVERY_LONG,
  parameter int SHORT_RECOVERY = `LPM_RECOVERY_SHORT,
  parameter int CNT_W          = 13
) (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // Register port
  input  wire logic [15:0] reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic      [7:0]  reg_rdata,
  // Processor side
  input  wire logic        wait_exec,
  input  wire logic        stop_exec,
  input  wire logic        irq_pending,
  input  wire logic        break_irq,
  input  wire logic        break_state,
  output logic             cpu_clk_en,
  output logic             periph_clk_en,
  output logic             clear_imask,
  output logic             start_stacking,
  output logic             break_wake,
  output logic             flag_clear_allow,
  // Clock generator side
  input  wire logic        osc_tick,
  output logic             bus_rate_clock_output_en,
  output logic             oscillator_rate_clock_en,
  // Options and reset sources
  input  wire logic        watchdog_disable_option,
  input  wire logic        short_stop_recovery_option,
  input  wire logic        por_event,
  input  wire logic        pin_reset,
  input  wire logic        watchdog_reset,
  input  wire logic        illegal_opcode_reset,
  input  wire logic        illegal_address_reset,
  input  wire logic        low_voltage_reset,
  output logic             watchdog_enable
);
  initial begin
    if (LONG_RECOVERY < 2 || LONG_RECOVERY > (1 << CNT_W) || SHORT_RECOVERY < 2
        || SHORT_RECOVERY > LONG_RECOVERY)
      $error("lpm_sequencer: recovery counts do not fit the counter");
  end

  lpm_state_t state;
  lpm_count_if #(.WIDTH(CNT_W)) cif ();
  lpm_counter u_counter (
    .ref_clk (ref_clk),
    .rst     (rst),
    .cif     (cif)
  );

  // Pin-level inputs are asynchronous to the bus clock
  logic [1:0] pin_raw;
  logic [1:0] pin_s2;
  assign pin_raw = {pin_reset, low_voltage_reset};
  for (genvar p = 0; p < 2; p++) begin : g_pin_sync
    logic stage1;
    logic stage2;
    always_ff @(posedge ref_clk) begin
      if (rst) begin
        stage1 <= 1'b0;
        stage2 <= 1'b0;
      end else begin
        stage1 <= pin_raw[p];
        stage2 <= stage1;
      end
    end
    assign pin_s2[p] = stage2;
  end

  logic any_reset;
  logic [7:0] cause_set;
  assign cause_set = {1'b0, pin_s2[1], watchdog_reset, illegal_opcode_reset,
                      illegal_address_reset, 1'b0, pin_s2[0], 1'b0};
  assign any_reset = |cause_set;

  lpm_wake_t wake;
  always_comb begin
    if (any_reset) begin
      wake = LPM_WAKE_RESET;
    end else if (break_irq) begin
      wake = LPM_WAKE_BREAK;
    end else if (irq_pending) begin
      wake = LPM_WAKE_IRQ;
    end else begin
      wake = LPM_WAKE_NONE;
    end
  end

  logic [CNT_W-1:0] next_target;
  logic [CNT_W-1:0] target;
  assign next_target = short_stop_recovery_option ? CNT_W'(SHORT_RECOVERY - 1)
                                                  : CNT_W'(LONG_RECOVERY - 1);
  logic stop_is_break;

  // Main mode sequence
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state         <= LPM_RUN;
      target        <= '0;
      stop_is_break <= 1'b0;
    end else begin
      case (state)
        LPM_RUN: begin
          if (stop_exec) begin
            state  <= LPM_STOP;
            target <= next_target;
          end else if (wait_exec) begin
            state <= LPM_WAIT;
          end
        end
        LPM_WAIT: begin
          if (wake != LPM_WAKE_NONE) begin
            state <= LPM_RUN;
          end
        end
        LPM_STOP: begin
          if (wake == LPM_WAKE_RESET) begin
            state <= LPM_RUN;
          end else if (wake != LPM_WAKE_NONE) begin
            state         <= LPM_RECOVER;
            stop_is_break <= (wake == LPM_WAKE_BREAK);
          end
        end
        LPM_RECOVER: begin
          if (any_reset) begin
            state <= LPM_RUN;
          end else if (osc_tick && cif.count == target) begin
            state <= LPM_RELEASE;
          end
        end
        LPM_RELEASE: begin
          state <= LPM_RUN;
        end
        default: begin
          state <= LPM_RUN;
        end
      endcase
    end
  end

  // Counter held through stop until recovery begins
  assign cif.hold = (state == LPM_STOP) || (state == LPM_RUN && stop_exec);
  assign cif.tick = osc_tick;

  // Next clock enables from the mode sequence
  logic next_cpu_clk_en;
  logic next_periph_clk_en;
  logic next_gen_clk_en;
  always_comb begin
    next_cpu_clk_en    = 1'b0;
    next_periph_clk_en = 1'b1;
    next_gen_clk_en    = 1'b1;
    case (state)
      LPM_RUN: begin
        next_cpu_clk_en    = !wait_exec && !stop_exec;
        next_periph_clk_en = !stop_exec;
        next_gen_clk_en    = !stop_exec;
      end
      LPM_WAIT: begin
        next_cpu_clk_en = wake != LPM_WAKE_NONE;
      end
      LPM_STOP: begin
        next_periph_clk_en = 1'b0;
        next_gen_clk_en    = 1'b0;
      end
      LPM_RECOVER: begin
        next_periph_clk_en = 1'b0;
      end
      LPM_RELEASE: begin
        next_cpu_clk_en = 1'b1;
      end
      default: begin
        next_cpu_clk_en = 1'b0;
      end
    endcase
  end

  // Processor clock returns in the same cycle as stacking
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cpu_clk_en <= 1'b1;
    end else begin
      cpu_clk_en <= next_cpu_clk_en;
    end
  end

  // Peripheral clock keeps running through wait
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      periph_clk_en <= 1'b1;
    end else begin
      periph_clk_en <= next_periph_clk_en;
    end
  end

  // Clocks restart on the second cycle of recovery, before the recovery count ends
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      bus_rate_clock_output_en <= 1'b1;
      oscillator_rate_clock_en <= 1'b1;
    end else begin
      bus_rate_clock_output_en <= next_gen_clk_en;
      oscillator_rate_clock_en <= next_gen_clk_en;
    end
  end

  // Watchdog stays on in wait unless the option disables it
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      watchdog_enable <= 1'b0;
    end else begin
      watchdog_enable <= !watchdog_disable_option;
    end
  end

  // Interrupt mask cleared by either low-power instruction
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      clear_imask <= 1'b0;
    end else begin
      clear_imask <= state == LPM_RUN && (wait_exec || stop_exec);
    end
  end

  // Stacking after stop waits for the recovery count
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      start_stacking <= 1'b0;
    end else begin
      start_stacking <= (state == LPM_WAIT && wake == LPM_WAKE_IRQ)
                        || (state == LPM_RELEASE && !stop_is_break);
    end
  end

  // Break wake reported to the processor
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      break_wake <= 1'b0;
    end else begin
      break_wake <= (state == LPM_WAIT && wake == LPM_WAKE_BREAK)
                    || (state == LPM_RELEASE && stop_is_break);
    end
  end

  // Break flag control register
  logic clear_enable;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      clear_enable <= 1'b0;
    end else if (reg_write && reg_addr == `LPM_ADDR_BREAK_CONTROL) begin
      clear_enable <= reg_wdata[`LPM_BIT_CLEAR_ENABLE];
    end
  end

  // Second steps of two-step clears are only suppressed, never remembered
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      flag_clear_allow <= 1'b1;
    end else begin
      flag_clear_allow <= !break_state || clear_enable;
    end
  end

  logic clears_ok;
  assign clears_ok = !break_state || clear_enable;

  // Break-exited-wait flag
  logic break_exited_wait_flag;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      break_exited_wait_flag <= 1'b0;
    end else if (state == LPM_WAIT && wake == LPM_WAKE_BREAK) begin
      break_exited_wait_flag <= 1'b1;
    end else if (reg_write && reg_addr == `LPM_ADDR_BREAK_STATUS && clears_ok
                 && !reg_wdata[`LPM_BIT_BREAK_WAIT]) begin
      break_exited_wait_flag <= 1'b0;
    end
  end

  // Reset cause flags; set wins over read-clear
  localparam logic [7:0] POR_CAUSE = `LPM_RESET_CAUSE_POR;
  logic [7:0] reset_cause;
  logic       cause_read;
  assign cause_read = reg_read && reg_addr == `LPM_ADDR_RESET_CAUSE && clears_ok;
  for (genvar b = 0; b < 8; b++) begin : g_cause
    logic flag;
    always_ff @(posedge ref_clk) begin
      if (rst || por_event) begin
        flag <= POR_CAUSE[b];
      end else if (cause_set[b]) begin
        flag <= 1'b1;
      end else if (cause_read) begin
        flag <= 1'b0;
      end
    end
    assign reset_cause[b] = flag;
  end

  // Read port
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_read) begin
      case (reg_addr)
        `LPM_ADDR_BREAK_STATUS:  reg_rdata <= 8'(break_exited_wait_flag) << `LPM_BIT_BREAK_WAIT;
        `LPM_ADDR_RESET_CAUSE:   reg_rdata <= reset_cause;
        `LPM_ADDR_BREAK_CONTROL: reg_rdata <= 8'(clear_enable) << `LPM_BIT_CLEAR_ENABLE;
        default:                 reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end
endmodule : lpm_sequencer

// ---- hdl/lpm_map.svh ----
// Register offsets, field positions, reset values and timing counts
`ifndef LPM_MAP_SVH
`define LPM_MAP_SVH
`define LPM_ADDR_BREAK_STATUS   16'hfe00
`define LPM_ADDR_RESET_CAUSE    16'hfe01
`define LPM_ADDR_BREAK_CONTROL  16'hfe03
`define LPM_BIT_BREAK_WAIT      1
`define LPM_BIT_CLEAR_ENABLE    0
`define LPM_BIT_POWER_ON        7
`define LPM_BIT_PIN             6
`define LPM_BIT_WATCHDOG        5
`define LPM_BIT_ILL_OPCODE      4
`define LPM_BIT_ILL_ADDRESS     3
`define LPM_BIT_LOW_VOLTAGE     1
`define LPM_RESET_CAUSE_POR     8'h80
`define LPM_RECOVERY_LONG       4096
`define LPM_RECOVERY_SHORT      32
`endif

// ---- hdl/lpm_pkg.sv ----
// Types shared by the low-power mode logic
package lpm_pkg;
  typedef enum logic [2:0] {
    LPM_RUN,
    LPM_WAIT,
    LPM_STOP,
    LPM_RECOVER,
    LPM_RELEASE
  } lpm_state_t;
  typedef enum logic [1:0] {
    LPM_WAKE_NONE,
    LPM_WAKE_RESET,
    LPM_WAKE_BREAK,
    LPM_WAKE_IRQ
  } lpm_wake_t;
endpackage : lpm_pkg

// ---- hdl/lpm_count_if.sv ----
// Link between the sequencer and its recovery counter
`timescale 1ns/10ps
interface lpm_count_if #(parameter int WIDTH = 13);
  logic             hold;
  logic             tick;
  logic [WIDTH-1:0] count;
  modport ctrl (output hold, output tick, input count);
  modport cnt  (input hold, input tick, output count);
endinterface : lpm_count_if

// ---- hdl/lpm_counter.sv ----
// Free-running internal counter, held while stopped
`timescale 1ns/10ps
module lpm_counter (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Control
  lpm_count_if.cnt cif
);
  // Reset and hold both clear it; otherwise it counts oscillator ticks
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cif.count <= '0;
    end else if (cif.hold) begin
      cif.count <= '0;
    end else if (cif.tick) begin
      cif.count <= cif.count + 1'b1;
    end
  end
endmodule : lpm_counter

// ---- tb/lpm_osc_model.sv ----
// Oscillator-rate tick source facing the sequencer
`timescale 1ns/10ps
module lpm_osc_model (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic rst,
  // Tick at half the bus rate
  output logic      osc_tick
);
  // Oscillator keeps running in stop, so recovery can be timed
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      osc_tick <= 1'b0;
    end else begin
      osc_tick <= ~osc_tick;
    end
  end
endmodule : lpm_osc_model

// ---- tb/lpm_seq_monitor.sv ----
// Port-level checks on the low-power sequencer
`timescale 1ns/10ps
module lpm_seq_monitor (
  // Clock and reset
  input wire logic       ref_clk,
  input wire logic       rst,
  // Watched ports
  input wire logic       reg_read,
  input wire logic [7:0] reg_rdata,
  input wire logic       wait_exec,
  input wire logic       stop_exec,
  input wire logic       irq_pending,
  input wire logic       break_irq,
  input wire logic       break_state,
  input wire logic       cpu_clk_en,
  input wire logic       periph_clk_en,
  input wire logic       clear_imask,
  input wire logic       start_stacking,
  input wire logic       bus_rate_clock_output_en,
  input wire logic       oscillator_rate_clock_en,
  input wire logic       flag_clear_allow,
  input wire logic       watchdog_disable_option,
  input wire logic       watchdog_enable
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  chk_wait_entry: assert property (wait_exec && cpu_clk_en && !irq_pending && !break_irq
    |=> !cpu_clk_en && periph_clk_en && clear_imask) else $error("wait entry wrong");
  chk_stop_gates: assert property (stop_exec && cpu_clk_en |=> clear_imask &&
    !bus_rate_clock_output_en && !oscillator_rate_clock_en && !periph_clk_en)
    else $error("stop entry wrong");
  chk_imask_pulse: assert property (clear_imask |=> !clear_imask)
    else $error("imask clear not a pulse");
  chk_stack_clocks: assert property (start_stacking |-> cpu_clk_en &&
    bus_rate_clock_output_en && oscillator_rate_clock_en) else $error("stacking before clocks");
  chk_stack_after: assert property (start_stacking |-> !$past(cpu_clk_en))
    else $error("stacking without wake");
  chk_rdata_idle: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
    else $error("read data outside read cycle");
  chk_wdog_follow: assert property (!$past(rst) |->
    watchdog_enable == !$past(watchdog_disable_option)) else $error("watchdog enable wrong");
  chk_clear_allow: assert property (!$past(rst) && !$past(break_state) |-> flag_clear_allow)
    else $error("flag clearing blocked outside break");
endmodule : lpm_seq_monitor

// ---- tb/testbench.sv ----
// Self-checking bench for the low-power sequencer
`timescale 1ns/10ps
module testbench;
  logic ref_clk = 1'b0, rst = 1'b1, osc_tick;
  logic [15:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, q;
  logic reg_write, reg_read, wait_exec, stop_exec, irq_pending, break_irq, break_state;
  logic cpu_clk_en, periph_clk_en, clear_imask, start_stacking, break_wake, flag_clear_allow;
  logic bus_rate_clock_output_en, oscillator_rate_clock_en, watchdog_enable;
  logic watchdog_disable_option, short_stop_recovery_option, por_event, pin_reset;
  logic watchdog_reset, illegal_opcode_reset, illegal_address_reset, low_voltage_reset;
  logic [5:0] src_row [6];
  logic [7:0] exp_row [6];
  int n_errors = 0, n_tests = 0, n;
  // Short counts keep the stop runs brief
  lpm_sequencer #(.LONG_RECOVERY(64), .SHORT_RECOVERY(8)) uut (.*);
  lpm_osc_model osc (.ref_clk(ref_clk), .rst(rst), .osc_tick(osc_tick));
  always #2 ref_clk = ~ref_clk;
  task complete_run;
    $display("tests=%0d errors=%0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : complete_run
  task check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge ref_clk) {reg_addr, reg_wdata, reg_write} <= {a, d, 1'b1};
    @(posedge ref_clk) reg_write <= 1'b0;
  endtask : wr
  task rd(input logic [15:0] a);
    @(posedge ref_clk) {reg_addr, reg_read} <= {a, 1'b1};
    @(posedge ref_clk) reg_read <= 1'b0;
    #1 q = reg_rdata;
  endtask : rd
  task pulse_instr(input logic stop);
    @(posedge ref_clk) {wait_exec, stop_exec} <= {!stop, stop};
    @(posedge ref_clk) {wait_exec, stop_exec} <= 2'b00;
    #1;
  endtask : pulse_instr
  // Bounded wait for the processor release
  task wake;
    n = 0;
    while (start_stacking !== 1'b1 && break_wake !== 1'b1) begin
      @(posedge ref_clk) #1 n++;
      if (n > 2000) begin
        n_errors++;
        complete_run;
      end
    end
  endtask : wake
  initial begin
    {reg_addr, reg_wdata, reg_write, reg_read, wait_exec, stop_exec} = '0;
    {irq_pending, break_irq, break_state, watchdog_disable_option} = '0;
    {short_stop_recovery_option, por_event, pin_reset, watchdog_reset} = '0;
    {illegal_opcode_reset, illegal_address_reset, low_voltage_reset} = '0;
    for (int i = 0; i < 6; i++) begin
      src_row[i] = 6'h20 >> i;
      exp_row[i] = (i == 5) ? 8'h02 : (8'h80 >> i);
    end
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    rd(16'hfe01);
    check(q, 8'h80);
    rd(16'hfe02);
    check(q, 8'h00);
    for (int i = 0; i < 6; i++) begin
      @(posedge ref_clk) {por_event, pin_reset, watchdog_reset, illegal_opcode_reset,
        illegal_address_reset, low_voltage_reset} <= src_row[i];
      @(posedge ref_clk) {por_event, pin_reset, watchdog_reset, illegal_opcode_reset,
        illegal_address_reset, low_voltage_reset} <= 6'h00;
      repeat (4) @(posedge ref_clk);
      rd(16'hfe01);
      check(q, exp_row[i]);
      rd(16'hfe01);
      check(q, 8'h00);
    end
    $display("reset cause rows done");
    pulse_instr(1'b0);
    check({cpu_clk_en, periph_clk_en, clear_imask, watchdog_enable}, 8'h07);
    @(posedge ref_clk) irq_pending <= 1'b1;
    wake;
    check({start_stacking, cpu_clk_en, 6'(n <= 2)}, 8'hc1);
    @(posedge ref_clk) irq_pending <= 1'b0;
    pulse_instr(1'b0);
    @(posedge ref_clk) {irq_pending, break_irq} <= 2'b11;
    wake;
    check({break_wake, start_stacking}, 8'h02);
    @(posedge ref_clk) {irq_pending, break_irq} <= 2'b00;
    rd(16'hfe00);
    check(q, 8'h02);
    wr(16'hfe00, 8'h00);
    rd(16'hfe00);
    check(q, 8'h00);
    $display("wait tests done");
    for (int s = 0; s < 2; s++) begin
      @(posedge ref_clk) {short_stop_recovery_option, watchdog_disable_option} <= {2{s[0]}};
      pulse_instr(1'b1);
      check({bus_rate_clock_output_en, oscillator_rate_clock_en, cpu_clk_en}, 8'h00);
      @(posedge ref_clk) irq_pending <= 1'b1;
      wake;
      // Two bus cycles per oscillator tick, plus wake and release
      check(8'(n >= (s ? 16 : 128) && n <= (s ? 20 : 132)), 8'h01);
      check({start_stacking, bus_rate_clock_output_en, oscillator_rate_clock_en}, 8'h07);
      @(posedge ref_clk) irq_pending <= 1'b0;
    end
    $display("stop tests done");
    @(posedge ref_clk) pin_reset <= 1'b1;
    @(posedge ref_clk) {pin_reset, break_state} <= 2'b01;
    repeat (4) @(posedge ref_clk);
    check({7'h0, flag_clear_allow}, 8'h00);
    rd(16'hfe01);
    check(q, 8'h40);
    rd(16'hfe01);
    check(q, 8'h40);
    wr(16'hfe03, 8'h01);
    rd(16'hfe03);
    check(q, 8'h01);
    rd(16'hfe01);
    rd(16'hfe01);
    check({q[7:1], flag_clear_allow}, 8'h01);
    $display("break protection done");
    complete_run;
  end
endmodule : testbench
bind lpm_sequencer lpm_seq_monitor mon (.*);
